// ===== core/tbw_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef TBW_REGS_SVH
`define TBW_REGS_SVH
`define TBW_OFF_TMR_CTRL 8'h00
`define TBW_OFF_COUNT0   8'h04
`define TBW_OFF_COUNT1   8'h08
`define TBW_OFF_TIMEBASE 8'h0c
`define TBW_OFF_TONE     8'h10
`define TBW_OFF_WD_CTRL  8'h14
`define TBW_OFF_CLK_CTRL 8'h18
`define TBW_OFF_STATUS   8'h1c
`define TBW_RUN_POS      0
`define TBW_GATE_POS     1
`define TBW_CT_POS       2
`define TBW_MODE_POS     3
`define TBW_T1_CTRL_POS  8
`define TBW_TONE_EN_POS  6
`define TBW_KEYTONE_POS  7
`define TBW_WD_RWT_POS   0
`define TBW_WD_EWT_POS   1
`define TBW_WD_WATCHDOG_RESET_FLAG_POS  2
`define TBW_WD_WATCHDOG_TIMEOUT_FLAG_POS  3
`define TBW_WD_IE_POS    4
`define TBW_WD_EA_POS    5
`define TBW_WD_SEL_POS   6
`define TBW_CFG_RST      5'h00
`define TBW_TB_RST       4'h0
`define TBW_TONE_RST     2'h0
`define TBW_WD_SEL_RST   2'h0
`define TBW_MC_CLKS      4
`define TBW_WDRST_MCS    2
`define TBW_WD_GRACE     512
`define TBW_WD_INT0      4096
`endif

// ===== core/tbw_pkg.sv
// types shared by the timer, tone and watchdog block
package tbw_pkg;
    typedef enum logic [1:0] {
        TBW_M13  = 2'h0,
        TBW_M16  = 2'h1,
        TBW_M8AR = 2'h2,
        TBW_MOFF = 2'h3
    } tbw_mode_e;
    typedef enum logic [2:0] {
        TBW_WD_RUN  = 3'h1,
        TBW_WD_WAIT = 3'h2,
        TBW_WD_RST  = 3'h4
    } tbw_wd_e;
endpackage

// ===== core/tbw_top.sv
// two timer/counters, tone output and watchdog behind an apb slave
//
// Operation
// - two identical timers, high and low bytes
// - time-base from osc/4, /64, /1024, sub-osc
// - overflow caught at phase 2, one per cycle
// - mode 0: high byte plus low five bits
// - low five bits step; low bit4 fall steps high
// - 13-bit wrap sets overflow flag
// - count only when run and gate allows
// - counter select picks clock or pin falls
// - mode 1 is full 16-bit counter
// - mode 2 reloads low from high, sets flag
// - timer time-base from timebase select register
// - timer 0 mode 2 drives tone pin
// - key-tone select routes key tone out
// - tone enable clear floats the pin
// - tone is timer0 overflow rate halved
// - watchdog free divider, independent irq, reset
// - restart bit clears count, self-clears
// - interval field picks 2^12..2^21 clocks
// - time-out sets flag, waits 512 clocks
// - no restart: reset two machine cycles
// - flag each interval; irq needs both enables
// - service entry clears overflow flag
// - power reset disables watchdog; own reset restarts
//
// Our own choices: the APB slave port and the register offsets.
`include "tbw_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module tbw_top #(
    parameter int unsigned WD_INT1 = 32768,
    parameter int unsigned WD_INT2 = 262144,
    parameter int unsigned WD_INT3 = 2097152
) (
    input  wire logic        sys_clk_in,
    input  wire logic        reset_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        sub_osc_clock_in,
    input  wire logic        count_input_pin_0_in,
    input  wire logic        count_input_pin_1_in,
    input  wire logic [1:0]  external_request_pin_in,
    input  wire logic        key_tone_signal_in,
    input  wire logic [1:0]  isr_ack_in,
    output logic      [1:0]  overflow_flag_out,
    output logic             watchdog_irq_out,
    output logic             sys_reset_out,
    output logic             tone_output_pin_out,
    output logic             tone_output_pin_oe_out
);
    import tbw_pkg::*;

    localparam int GRC = `TBW_WD_GRACE;
    localparam int RSC = `TBW_MC_CLKS * `TBW_WDRST_MCS;
    localparam logic [8:0] GR_LAST = 9'(GRC - 1);
    localparam logic [2:0] RS_LAST = 3'(RSC - 1);

    // next count for one step, bit 16 flags overflow
    function automatic logic [16:0] tbw_next(
        input logic [1:0] m,
        input logic [7:0] hi,
        input logic [7:0] lo
    );
        logic [16:0] r;
        r = {1'b0, hi, lo};
        unique case (m)
            TBW_M13: begin
                r[4:0] = lo[4:0] + 5'h01;
                if (lo[4:0] == 5'h1f) begin
                    r[15:8] = hi + 8'h01;
                    r[16]   = (hi == 8'hff);
                end
            end
            TBW_M16: r = {1'b0, hi, lo} + 17'h00001;
            TBW_M8AR: begin
                if (lo == 8'hff) begin
                    r = {1'b1, hi, hi};
                end else begin
                    r[7:0] = lo + 8'h01;
                end
            end
            default: r = {1'b0, hi, lo};
        endcase
        return r;
    endfunction

    // watchdog interval in clocks
    function automatic logic [21:0] wd_lim(input logic [1:0] sel);
        logic [21:0] v;
        unique case (sel)
            2'h0: v = 22'(`TBW_WD_INT0);
            2'h1: v = 22'(WD_INT1);
            2'h2: v = 22'(WD_INT2);
            2'h3: v = 22'(WD_INT3);
        endcase
        return v;
    endfunction

    // register state
    logic [1:0][4:0]  cfg_q;
    logic [3:0]       tb_q;
    logic [1:0]       tone_cfg_q;
    logic [1:0]       wd_sel_q;
    logic             ewt_q;
    logic             wdie_q;
    logic             ea_q;
    logic             watchdog_timeout_flag_q;
    logic             watchdog_reset_flag_q;
    logic             rwt_q;
    logic [31:0]      prdata_q;
    logic             pready_q;
    logic             pslverr_q;
    logic [9:0]       pre_q;
    logic [1:0]       mc_q;
    logic [5:0]       s1_q;
    logic [5:0]       s2_q;
    logic [5:0]       s3_q;
    logic             tone_tgl_q;
    logic             tone_out_q;
    logic             tone_oe_q;
    logic             wd_irq_q;
    tbw_wd_e          st_q;
    logic [21:0]      wd_cnt_q;
    logic [8:0]       gr_q;
    logic [2:0]       rc_q;
    logic [1:0][15:0] cnt_w;
    logic [1:0]       ovf_w;
    logic [1:0]       step;
    logic [1:0]       ovf_ev;

    // apb decode
    wire mapped  = (paddr_in[7:5] == 3'h0) && (paddr_in[1:0] == 2'h0);
    wire acc     = psel_in & penable_in;
    wire wr      = acc & pwrite_in & pready_q & mapped;
    wire wr_ctrl = wr & (paddr_in == `TBW_OFF_TMR_CTRL);
    wire wr_tb   = wr & (paddr_in == `TBW_OFF_TIMEBASE);
    wire wr_tone = wr & (paddr_in == `TBW_OFF_TONE);
    wire wr_wd   = wr & (paddr_in == `TBW_OFF_WD_CTRL);
    wire wr_clk  = wr & (paddr_in == `TBW_OFF_CLK_CTRL);
    wire wr_stat = wr & (paddr_in == `TBW_OFF_STATUS);
    wire wd_rst  = (st_q == TBW_WD_RST);

    // read selection; restart bit always reads back zero
    wire [31:0] rd_word =
        (paddr_in == `TBW_OFF_TMR_CTRL) ?
            {19'h0, cfg_q[1], 3'h0, cfg_q[0]} :
        (paddr_in == `TBW_OFF_COUNT0) ? {16'h0, cnt_w[0]} :
        (paddr_in == `TBW_OFF_COUNT1) ? {16'h0, cnt_w[1]} :
        (paddr_in == `TBW_OFF_TIMEBASE) ? {28'h0, tb_q} :
        (paddr_in == `TBW_OFF_TONE) ? {24'h0, tone_cfg_q, 6'h0} :
        (paddr_in == `TBW_OFF_WD_CTRL) ?
            {26'h0, ea_q, wdie_q, watchdog_timeout_flag_q, watchdog_reset_flag_q, ewt_q, 1'b0} :
        (paddr_in == `TBW_OFF_CLK_CTRL) ? {24'h0, wd_sel_q, 6'h0} :
        (paddr_in == `TBW_OFF_STATUS) ? {30'h0, ovf_w} : 32'h0;

    // one wait state, then ready with data or error
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q  <= acc & ~pready_q;
            pslverr_q <= acc & ~pready_q & ~mapped;
            if (acc & ~pready_q) begin
                prdata_q <= mapped ? rd_word : 32'h0;
            end
        end
    end

    // pin synchronisers and edge history
    wire [5:0] raw = {key_tone_signal_in, external_request_pin_in,
                      count_input_pin_1_in, count_input_pin_0_in,
                      sub_osc_clock_in};
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            s1_q <= 6'h0;
            s2_q <= 6'h0;
            s3_q <= 6'h0;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    wire [5:0] fall = s3_q & ~s2_q;

    // prescaler and machine-cycle phase
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            pre_q <= 10'h000;
            mc_q  <= 2'h0;
        end else begin
            pre_q <= pre_q + 10'h001;
            mc_q  <= mc_q + 2'h1;
        end
    end
    wire phase2 = (mc_q == 2'h1);

    // falling edges of the four time-bases
    wire [3:0] tick = {fall[0], &pre_q, &pre_q[5:0], &pre_q[1:0]};

    // configuration registers
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            cfg_q      <= {`TBW_CFG_RST, `TBW_CFG_RST};
            tb_q       <= `TBW_TB_RST;
            tone_cfg_q <= `TBW_TONE_RST;
            wd_sel_q   <= `TBW_WD_SEL_RST;
            wdie_q     <= 1'b0;
            ea_q       <= 1'b0;
        end else if (wd_rst) begin
            cfg_q      <= {`TBW_CFG_RST, `TBW_CFG_RST};
            tone_cfg_q <= `TBW_TONE_RST;
        end else begin
            if (wr_ctrl) begin
                cfg_q[0] <= pwdata_in[4:0];
                cfg_q[1] <= pwdata_in[`TBW_T1_CTRL_POS +: 5];
            end
            if (wr_tb) begin
                tb_q <= pwdata_in[3:0];
            end
            if (wr_tone) begin
                tone_cfg_q <= pwdata_in[`TBW_TONE_EN_POS +: 2];
            end
            if (wr_clk) begin
                wd_sel_q <= pwdata_in[`TBW_WD_SEL_POS +: 2];
            end
            if (wr_wd) begin
                wdie_q <= pwdata_in[`TBW_WD_IE_POS];
                ea_q   <= pwdata_in[`TBW_WD_EA_POS];
            end
        end
    end

    // the two timer/counters
    for (genvar i = 0; i < 2; i++) begin : g_tmr
        logic [7:0] hi_q;
        logic [7:0] lo_q;
        logic       pend_q;
        logic       flag_q;
        wire [4:0]  c  = cfg_q[i];
        wire [1:0]  ts = tb_q[2*i +: 2];
        wire ev   = c[`TBW_CT_POS] ? fall[1+i] : tick[ts];
        wire gok  = ~c[`TBW_GATE_POS] | s2_q[3+i];
        wire [16:0] nx = tbw_next(c[`TBW_MODE_POS +: 2], hi_q, lo_q);
        wire cw   = wr & (paddr_in == (i == 0 ? `TBW_OFF_COUNT0
                                              : `TBW_OFF_COUNT1));
        wire clr  = isr_ack_in[i] | (wr_stat & pwdata_in[i]);
        assign step[i]   = c[`TBW_RUN_POS] & gok & ev;
        assign ovf_ev[i] = step[i] & nx[16];
        assign cnt_w[i]  = {hi_q, lo_q};
        assign ovf_w[i]  = flag_q;

        // count bytes: software write beats a step
        always_ff @(posedge sys_clk_in or posedge reset_in) begin
            if (reset_in) begin
                hi_q <= 8'h00;
                lo_q <= 8'h00;
            end else if (cw) begin
                hi_q <= pwdata_in[15:8];
                lo_q <= pwdata_in[7:0];
            end else if (step[i]) begin
                hi_q <= nx[15:8];
                lo_q <= nx[7:0];
            end
        end

        // overflow held until phase 2; set wins over clear
        always_ff @(posedge sys_clk_in or posedge reset_in) begin
            if (reset_in) begin
                pend_q <= 1'b0;
                flag_q <= 1'b0;
            end else begin
                pend_q <= ovf_ev[i] | (pend_q & ~phase2);
                flag_q <= (phase2 & pend_q) | (flag_q & ~clr);
            end
        end
    end

    // tone divider and pin drive
    wire t0_ar = (cfg_q[0][`TBW_MODE_POS +: 2] == TBW_M8AR);
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            tone_tgl_q <= 1'b0;
            tone_out_q <= 1'b0;
            tone_oe_q  <= 1'b0;
        end else begin
            if (ovf_ev[0] & t0_ar) begin
                tone_tgl_q <= ~tone_tgl_q;
            end
            tone_out_q <= tone_cfg_q[1] ? s2_q[5] : tone_tgl_q;
            tone_oe_q  <= tone_cfg_q[0];
        end
    end

    // watchdog counter and sequencer
    wire [21:0] lim_m1 = wd_lim(wd_sel_q) - 22'h000001;
    wire tmo       = (wd_cnt_q == lim_m1) & ~rwt_q;
    wire grace_end = (st_q == TBW_WD_WAIT) & (gr_q == GR_LAST) & ~rwt_q;
    wire rst_go    = grace_end & ewt_q;

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_q     <= TBW_WD_RUN;
            wd_cnt_q <= 22'h000000;
            gr_q     <= 9'h000;
            rc_q     <= 3'h0;
        end else begin
            wd_cnt_q <= (rwt_q | tmo | wd_rst) ? 22'h000000
                      : wd_cnt_q + 22'h000001;
            unique case (st_q)
                TBW_WD_RUN: begin
                    gr_q <= 9'h000;
                    if (tmo) begin
                        st_q <= TBW_WD_WAIT;
                    end
                end
                TBW_WD_WAIT: begin
                    gr_q <= gr_q + 9'h001;
                    rc_q <= 3'h0;
                    if (rwt_q) begin
                        st_q <= TBW_WD_RUN;
                    end else if (gr_q == GR_LAST) begin
                        // with reset disabled, a time-out on this edge opens a fresh grace
                        st_q <= ewt_q ? TBW_WD_RST
                              : (tmo ? TBW_WD_WAIT : TBW_WD_RUN);
                    end
                end
                TBW_WD_RST: begin
                    rc_q <= rc_q + 3'h1;
                    if (rc_q == RS_LAST) begin
                        st_q <= TBW_WD_RUN;
                    end
                end
            endcase
        end
    end

    // watchdog flags, restart pulse and interrupt
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ewt_q    <= 1'b0;
            watchdog_timeout_flag_q   <= 1'b0;
            watchdog_reset_flag_q   <= 1'b0;
            rwt_q    <= 1'b0;
            wd_irq_q <= 1'b0;
        end else begin
            rwt_q <= wr_wd & pwdata_in[`TBW_WD_RWT_POS];
            if (wr_wd) begin
                ewt_q <= pwdata_in[`TBW_WD_EWT_POS];
            end
            watchdog_timeout_flag_q <= tmo | (watchdog_timeout_flag_q & ~wd_rst &
                      ~(wr_wd & ~pwdata_in[`TBW_WD_WATCHDOG_TIMEOUT_FLAG_POS]));
            watchdog_reset_flag_q <= rst_go | (watchdog_reset_flag_q &
                      ~(wr_wd & ~pwdata_in[`TBW_WD_WATCHDOG_RESET_FLAG_POS]));
            wd_irq_q <= watchdog_timeout_flag_q & wdie_q & ea_q;
        end
    end

    // outputs straight from flops
    assign prdata_out             = prdata_q;
    assign pready_out             = pready_q;
    assign pslverr_out            = pslverr_q;
    assign overflow_flag_out      = ovf_w;
    assign watchdog_irq_out       = wd_irq_q;
    assign sys_reset_out          = st_q[2];
    assign tone_output_pin_out    = tone_out_q;
    assign tone_output_pin_oe_out = tone_oe_q;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (reset_in);

    wd_rst_len_a: assert property (
        $rose(sys_reset_out) |-> sys_reset_out[*8] ##1 !sys_reset_out)
        else $error("watchdog reset not eight clocks");
    wd_rst_cause_a: assert property (
        $rose(sys_reset_out) |-> watchdog_reset_flag_q && $past(ewt_q)
            && $past(gr_q) == GR_LAST)
        else $error("watchdog reset without grace expiry");
    wd_flag_set_a: assert property (
        tmo |=> watchdog_timeout_flag_q && st_q != TBW_WD_RUN)
        else $error("time-out did not set flag");
    wd_restart_a: assert property (
        rwt_q |=> wd_cnt_q == 22'h0 && !rwt_q)
        else $error("restart did not clear count");
    wd_irq_gate_a: assert property (
        watchdog_irq_out |-> $past(watchdog_timeout_flag_q && wdie_q && ea_q))
        else $error("watchdog irq without enables");
    ovf_phase_a: assert property (
        $rose(overflow_flag_out[0]) |-> $past(mc_q) == 2'h1)
        else $error("overflow caught off phase 2");
    reload_a: assert property (
        step[0] && t0_ar && cnt_w[0][7:0] == 8'hff && !wr
            |=> cnt_w[0][7:0] == cnt_w[0][15:8])
        else $error("mode 2 reload missing");
    stopped_a: assert property (
        !cfg_q[1][`TBW_RUN_POS] && !wr |=> $stable(cnt_w[1]))
        else $error("timer counted while stopped");
    apb_ready_a: assert property (
        acc && !pready_q |=> pready_out ##1 !pready_out)
        else $error("apb ready not one wait state");

endmodule // tbw_top

`default_nettype wire

// ===== dv/tbw_top_test.sv
// self-checking bench for the timer, tone and watchdog block
`include "tbw_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module tbw_top_test;
    import tbw_pkg::*;

    localparam int unsigned IV1 = 64;
    localparam int unsigned IV2 = 128;
    localparam int unsigned IV3 = 256;

    logic        sys_clk_in = 1'b0;
    logic        reset_in   = 1'b1;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [7:0]  paddr      = 8'h00;
    logic [31:0] pwdata     = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sub_osc    = 1'b0;
    logic [1:0]  cnt_pin    = 2'h0;
    logic [1:0]  ext_req    = 2'h0;
    logic        key_tone   = 1'b0;
    logic [1:0]  isr_ack    = 2'h0;
    logic [1:0]  ovf;
    logic        wd_irq;
    logic        sys_rst;
    logic        tone;
    logic        tone_oe;
    logic        rst_seen   = 1'b0;
    int          cyc        = 0;
    int          failures   = 0;
    int          n_compared = 0;
    int          seed;

    // clock, cycle count, slow sub-oscillator of 32 clocks
    always #5 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc % 16 == 15) begin
            sub_osc <= ~sub_osc;
        end
        if (sys_rst === 1'b1) begin
            rst_seen <= 1'b1;
        end
    end

    tbw_top #(.WD_INT1(IV1), .WD_INT2(IV2), .WD_INT3(IV3)) u_dut (
        .sys_clk_in             (sys_clk_in),
        .reset_in               (reset_in),
        .psel_in                (psel),
        .penable_in             (penable),
        .pwrite_in              (pwrite),
        .paddr_in               (paddr),
        .pwdata_in              (pwdata),
        .prdata_out             (prdata),
        .pready_out             (pready),
        .pslverr_out            (pslverr),
        .sub_osc_clock_in       (sub_osc),
        .count_input_pin_0_in   (cnt_pin[0]),
        .count_input_pin_1_in   (cnt_pin[1]),
        .external_request_pin_in(ext_req),
        .key_tone_signal_in     (key_tone),
        .isr_ack_in             (isr_ack),
        .overflow_flag_out      (ovf),
        .watchdog_irq_out       (wd_irq),
        .sys_reset_out          (sys_rst),
        .tone_output_pin_out    (tone),
        .tone_output_pin_oe_out (tone_oe)
    );

    // verdict and end of run
    task automatic tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic fail(input string msg);
        failures++;
        $display("mismatch at %0t: %s", $time, msg);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        n_compared++;
        if (got !== exp) begin
            fail($sformatf("%s got %h exp %h", msg, got, exp));
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi,
                           input string msg);
        n_compared++;
        if (got < lo || got > hi) begin
            fail($sformatf("%s got %0d", msg, got));
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int          n;
        logic        got;
        logic        er;
        logic [31:0] rd;
        n = 0;
        @(posedge sys_clk_in);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk_in);
        penable <= 1'b1;
        // answer sampled mid-cycle, taken at the following rising edge
        do begin
            @(negedge sys_clk_in);
            n++;
            got = pready;
            rd  = prdata;
            er  = pslverr;
            @(posedge sys_clk_in);
        end while (got !== 1'b1 && n < 20);
        if (got !== 1'b1) begin
            fail("apb timeout");
            tally_and_finish();
        end
        r = er ? 32'hdead0000 | rd : rd;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask

    function automatic logic sig(input int w);
        case (w)
            0: return ovf[0];
            1: return wd_irq;
            2: return sys_rst;
            default: return tone;
        endcase
    endfunction

    task automatic wait_for(input int w, input logic v, input int lim);
        int n;
        n = 0;
        while (sig(w) !== v && n < lim) begin
            @(negedge sys_clk_in);
            n++;
        end
        if (n >= lim) begin
            fail("wait timeout");
            tally_and_finish();
        end
    endtask

    logic [7:0]  offs [8] = '{`TBW_OFF_TMR_CTRL, `TBW_OFF_COUNT0,
        `TBW_OFF_COUNT1, `TBW_OFF_TIMEBASE, `TBW_OFF_TONE,
        `TBW_OFF_WD_CTRL, `TBW_OFF_CLK_CTRL, `TBW_OFF_STATUS};
    int          divs [4] = '{4, 64, 1024, 32};
    int          ivs  [4] = '{`TBW_WD_INT0, IV1, IV2, IV3};

    // main sequence
    initial begin
        logic [31:0] r;
        logic [15:0] v;
        int          n;
        int          t;
        seed = 20432;
        repeat (8) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        foreach (offs[i]) begin
            apb(1'b0, offs[i], 32'h0, r);
            chk(r, 32'h0, "reset value");
        end
        apb(1'b0, 8'h20, 32'h0, r);
        chk(r, 32'hdead0000, "unmapped read");
        v = 16'($random(seed));
        wr(`TBW_OFF_COUNT0, {16'hffff, v});
        apb(1'b0, `TBW_OFF_COUNT0, 32'h0, r);
        chk(r, {16'h0, v}, "count bytes");
        // mode 0 wrap from all ones, slow clock
        wr(`TBW_OFF_TIMEBASE, 32'h2);
        wr(`TBW_OFF_COUNT0, 32'hffff);
        wr(`TBW_OFF_TMR_CTRL, 32'h01);
        wait_for(0, 1'b1, 1200);
        apb(1'b0, `TBW_OFF_COUNT0, 32'h0, r);
        chk(r & 32'hff1f, 32'h0, "mode 0 wrap");
        wr(`TBW_OFF_STATUS, 32'h1);
        repeat (3) @(posedge sys_clk_in);
        chk({31'h0, ovf[0]}, 32'h0, "status clear");
        // mode 1 wrap, cleared by service entry
        wr(`TBW_OFF_COUNT0, 32'hfffe);
        wr(`TBW_OFF_TMR_CTRL, 32'h09);
        wait_for(0, 1'b1, 2200);
        apb(1'b0, `TBW_OFF_COUNT0, 32'h0, r);
        chk(r, 32'h0, "mode 1 wrap");
        isr_ack <= 2'h1;
        @(posedge sys_clk_in);
        isr_ack <= 2'h0;
        repeat (3) @(posedge sys_clk_in);
        chk({31'h0, ovf[0]}, 32'h0, "ack clear");
        // mode 2 reload
        wr(`TBW_OFF_TMR_CTRL, 32'h0);
        wr(`TBW_OFF_COUNT0, 32'hf0ff);
        wr(`TBW_OFF_TMR_CTRL, 32'h11);
        wait_for(0, 1'b1, 1200);
        apb(1'b0, `TBW_OFF_COUNT0, 32'h0, r);
        chk(r, 32'hf0f0, "reload");
        wr(`TBW_OFF_TMR_CTRL, 32'h0);
        // timer 1 gated by its request pin
        wr(`TBW_OFF_TIMEBASE, 32'h0);
        wr(`TBW_OFF_COUNT1, 32'h0);
        wr(`TBW_OFF_TMR_CTRL, 32'h0b00);
        repeat (200) @(posedge sys_clk_in);
        apb(1'b0, `TBW_OFF_COUNT1, 32'h0, r);
        chk(r, 32'h0, "gate closed");
        ext_req <= 2'h2;
        repeat (200) @(posedge sys_clk_in);
        apb(1'b0, `TBW_OFF_COUNT1, 32'h0, r);
        chk_rng(int'(r), 45, 60, "gate open");
        // counter mode on pin falls
        wr(`TBW_OFF_TMR_CTRL, 32'h0);
        wr(`TBW_OFF_COUNT1, 32'h0);
        wr(`TBW_OFF_TMR_CTRL, 32'h0d00);
        n = 3 + ($unsigned($random(seed)) % 8);
        repeat (n) begin
            cnt_pin[1] <= 1'b1;
            repeat (4) @(posedge sys_clk_in);
            cnt_pin[1] <= 1'b0;
            repeat (4) @(posedge sys_clk_in);
        end
        repeat (6) @(posedge sys_clk_in);
        apb(1'b0, `TBW_OFF_COUNT1, 32'h0, r);
        chk(r, 32'(n), "pin falls");
        wr(`TBW_OFF_COUNT1, 32'hffff);
        cnt_pin[1] <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        cnt_pin[1] <= 1'b0;
        repeat (12) @(posedge sys_clk_in);
        chk({31'h0, ovf[1]}, 32'h1, "timer 1 flag");
        wr(`TBW_OFF_STATUS, 32'h2);
        repeat (3) @(posedge sys_clk_in);
        chk({31'h0, ovf[1]}, 32'h0, "timer 1 clear");
        // each time-base source for timer 1
        foreach (divs[i]) begin
            wr(`TBW_OFF_TMR_CTRL, 32'h0);
            wr(`TBW_OFF_COUNT1, 32'h0);
            wr(`TBW_OFF_TIMEBASE, 32'(i) << 2);
            wr(`TBW_OFF_TMR_CTRL, 32'h0900);
            repeat (2048) @(posedge sys_clk_in);
            apb(1'b0, `TBW_OFF_COUNT1, 32'h0, r);
            t = 2048 / divs[i];
            chk_rng(int'(r), t - 2, t + 4, "time-base");
        end
        // tone from timer 0 in mode 2, reload fe
        wr(`TBW_OFF_TMR_CTRL, 32'h0);
        wr(`TBW_OFF_TIMEBASE, 32'h0);
        wr(`TBW_OFF_COUNT0, 32'hfefe);
        wr(`TBW_OFF_TMR_CTRL, 32'h11);
        wr(`TBW_OFF_TONE, 32'h40);
        repeat (40) @(posedge sys_clk_in);
        chk({31'h0, tone_oe}, 32'h1, "tone driven");
        wait_for(3, ~tone, 100);
        t = cyc;
        wait_for(3, ~tone, 100);
        chk(32'(cyc - t), 32'h8, "tone half period");
        wr(`TBW_OFF_TONE, 32'hc0);
        repeat (4) begin
            key_tone <= 1'($random(seed));
            repeat (8) @(posedge sys_clk_in);
            chk({31'h0, tone}, {31'h0, key_tone}, "key tone");
        end
        wr(`TBW_OFF_TONE, 32'h0);
        repeat (3) @(posedge sys_clk_in);
        chk({31'h0, tone_oe}, 32'h0, "tone float");
        wr(`TBW_OFF_TMR_CTRL, 32'h0);
        // every watchdog interval code
        foreach (ivs[i]) begin
            wr(`TBW_OFF_CLK_CTRL, 32'(i) << 6);
            wr(`TBW_OFF_WD_CTRL, 32'h31);
            t = cyc;
            wait_for(1, 1'b1, ivs[i] + 40);
            chk_rng(cyc - t, ivs[i] - 4, ivs[i] + 6, "interval");
            wr(`TBW_OFF_WD_CTRL, 32'h30);
        end
        // masked interrupt, flag still set
        wr(`TBW_OFF_CLK_CTRL, 32'h40);
        wr(`TBW_OFF_WD_CTRL, 32'h21);
        repeat (200) @(posedge sys_clk_in);
        chk({31'h0, wd_irq}, 32'h0, "irq masked");
        apb(1'b0, `TBW_OFF_WD_CTRL, 32'h0, r);
        chk(r & 32'h9, 32'h8, "flag, restart reads 0");
        // periodic restart keeps reset away
        wr(`TBW_OFF_CLK_CTRL, 32'h0);
        repeat (5) begin
            wr(`TBW_OFF_WD_CTRL, 32'h03);
            repeat (3000) @(posedge sys_clk_in);
        end
        chk({31'h0, rst_seen}, 32'h0, "restart held off");
        // no restart: watchdog reset
        wr(`TBW_OFF_TMR_CTRL, 32'h09);
        wr(`TBW_OFF_WD_CTRL, 32'h33);
        wait_for(1, 1'b1, 4200);
        t = cyc;
        wait_for(2, 1'b1, 600);
        chk_rng(cyc - t, 508, 516, "grace");
        t = cyc;
        wait_for(2, 1'b0, 20);
        chk(32'(cyc - t), 32'h8, "reset length");
        repeat (4) @(posedge sys_clk_in);
        apb(1'b0, `TBW_OFF_WD_CTRL, 32'h0, r);
        chk(r & 32'he, 32'h6, "reset flags");
        apb(1'b0, `TBW_OFF_TMR_CTRL, 32'h0, r);
        chk(r, 32'h0, "config cleared");
        tally_and_finish();
    end
endmodule // tbw_top_test

`default_nettype wire
